// >>> design/shc_pkg.sv
// Constants, types and decoders shared by the standby halt control block
package shc_pkg;
  // Register map
  localparam logic [7:0] SHC_SMC_ADDR     = 8'h1e;
  localparam logic [7:0] SHC_SMC_RESET    = 8'h00;
  // Field positions inside standby_mode_control
  localparam int         SHC_PSRAM_BIT    = 7;
  localparam int         SHC_SCOUT_BIT    = 5;
  localparam int         SHC_CLKTRI_BIT   = 4;
  localparam int         SHC_HALTM_HI_BIT = 3;
  localparam int         SHC_HALTM_LO_BIT = 2;
  localparam int         SHC_KEEP_BIT     = 0;
  // Halt mode encodings
  localparam logic [1:0] SHC_MODE_RUN     = 2'h0;
  localparam logic [1:0] SHC_MODE_STOP    = 2'h1;
  localparam logic [1:0] SHC_MODE_IDLE    = 2'h2;
  // Interrupt sources and the fixed level of the non-maskable one
  localparam logic [1:0] SHC_SRC_NMI      = 2'h0;
  localparam logic [1:0] SHC_SRC_EXT0     = 2'h1;
  localparam logic [1:0] SHC_SRC_OTHER    = 2'h2;
  localparam logic [2:0] SHC_NMI_LEVEL    = 3'h7;
  // Timing: clock is the oscillator itself
  localparam int         SHC_CLK_HZ       = 25_000_000;
  localparam int         SHC_OSC_HZ       = 25_000_000;
  localparam int         SHC_STATE_DIV    = 2;
  localparam int         SHC_ENTRY_OSC    = 3;
  localparam int         SHC_ENTRY_CYC    =
    (SHC_ENTRY_OSC * (SHC_CLK_HZ / SHC_OSC_HZ) < 1) ? 1 :
    SHC_ENTRY_OSC * (SHC_CLK_HZ / SHC_OSC_HZ);
  localparam logic [1:0] SHC_ENTRY_LAST   = 2'(SHC_ENTRY_CYC - 1);

  typedef enum logic [1:0] {SHC_RUN_S, SHC_ENTRY_S, SHC_HALT_S} shc_state_t;

  // Does this mode go through the clock-stopping entry window
  function automatic logic shc_slow_entry(input logic [1:0] mode);
    return (mode == SHC_MODE_STOP) || (mode == SHC_MODE_IDLE);
  endfunction

  // Effective priority level of a request
  function automatic logic [2:0] shc_level(input logic [1:0] src,
                                           input logic [2:0] lvl);
    return (src == SHC_SRC_NMI) ? SHC_NMI_LEVEL : lvl;
  endfunction
endpackage

// >>> design/shc_irq_if.sv
// Carrier between halt sequencer and pending interrupt store
`timescale 1ns/1ps
interface shc_irq_if;
  logic       hold_set;   // Request caught in the entry window
  logic       new_set;    // Request other than an entry-window NMI or external zero
  logic [1:0] req_src;    // Source of the request
  logic [2:0] req_lvl;    // Effective level of the request
  logic       svc_valid;  // A request waits for service
  logic [1:0] svc_src;    // Source to serve now
  logic       svc_ack;    // CPU takes the offered request

  modport seq  (output hold_set, new_set, req_src, req_lvl, svc_ack,
                input  svc_valid, svc_src);
  modport store(input  hold_set, new_set, req_src, req_lvl, svc_ack,
                output svc_valid, svc_src);
endinterface

// >>> design/shc_state_div.sv
// Divides the oscillator clock by two into the state tick
`timescale 1ns/1ps
module shc_state_div
  import shc_pkg::*;
(
  input  wire logic clk,        // Oscillator clock
  input  wire logic resetn,     // Asynchronous reset, active low
  output logic      state_tick, // One-cycle pulse per state
  output logic      phase       // Half-rate square wave
);
  logic phase_r;
  logic phase_nxt;

  // Toggle every oscillator cycle
  always_comb
  begin
    phase_nxt = ~phase_r;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      phase_r <= 1'b0;
    else
      phase_r <= phase_nxt;
  end

  // One state spans two oscillator cycles
  assign state_tick = phase_r;  // see [RL6]
  assign phase      = phase_r;

  property p_state_period;
    @(posedge clk) disable iff (!resetn)
      state_tick |=> !state_tick ##1 state_tick;
  endproperty
  a_state_period: assert property (p_state_period)  // see [RL6]
    else $error("state tick period is not two clocks");
endmodule // shc_state_div

// >>> design/shc_irq_store.sv
// Pending interrupt store with priority resolution
`timescale 1ns/1ps
module shc_irq_store
  import shc_pkg::*;
(
  input  wire logic clk,     // Oscillator clock
  input  wire logic resetn,  // Asynchronous reset, active low
  shc_irq_if.store  irq      // Requests in, service offer out
);
  logic       held_v_r, held_v_nxt;
  logic [1:0] held_src_r, held_src_nxt;
  logic [2:0] held_lvl_r, held_lvl_nxt;
  logic       new_v_r, new_v_nxt;
  logic [1:0] new_src_r, new_src_nxt;
  logic [2:0] new_lvl_r, new_lvl_nxt;
  logic       pick_held;

  // Higher level first, held one wins a tie since it came first
  assign pick_held = held_v_r && (!new_v_r || held_lvl_r >= new_lvl_r);
  assign irq.svc_valid = held_v_r | new_v_r;
  assign irq.svc_src   = pick_held ? held_src_r : new_src_r;  // see [RL8]

  // Slot updates; a set in the same cycle as an ack wins
  always_comb
  begin
    held_v_nxt   = held_v_r & ~(irq.svc_ack & pick_held);
    held_src_nxt = held_src_r;
    held_lvl_nxt = held_lvl_r;
    new_v_nxt    = new_v_r & ~(irq.svc_ack & ~pick_held);
    new_src_nxt  = new_src_r;
    new_lvl_nxt  = new_lvl_r;
    if (irq.hold_set && !held_v_nxt)
    begin
      held_v_nxt   = 1'b1;  // see [RL7]
      held_src_nxt = irq.req_src;
      held_lvl_nxt = irq.req_lvl;
    end
    if (irq.new_set && !new_v_nxt)
    begin
      new_v_nxt   = 1'b1;
      new_src_nxt = irq.req_src;
      new_lvl_nxt = irq.req_lvl;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      held_v_r   <= 1'b0;
      held_src_r <= 2'h0;
      held_lvl_r <= 3'h0;
      new_v_r    <= 1'b0;
      new_src_r  <= 2'h0;
      new_lvl_r  <= 3'h0;
    end
    else
    begin
      held_v_r   <= held_v_nxt;
      held_src_r <= held_src_nxt;
      held_lvl_r <= held_lvl_nxt;
      new_v_r    <= new_v_nxt;
      new_src_r  <= new_src_nxt;
      new_lvl_r  <= new_lvl_nxt;
    end
  end

  property p_prio_order;
    @(posedge clk) disable iff (!resetn)
      held_v_r && new_v_r && (held_lvl_r != new_lvl_r) |->
        irq.svc_src == ((held_lvl_r > new_lvl_r) ? held_src_r : new_src_r);
  endproperty
  a_prio_order: assert property (p_prio_order)  // see [RL8]
    else $error("lower level served before higher level");

  property p_other_follows;
    @(posedge clk) disable iff (!resetn)
      held_v_r && new_v_r && irq.svc_ack && !irq.hold_set && !irq.new_set
        |=> irq.svc_valid;
  endproperty
  a_other_follows: assert property (p_other_follows)  // see [RL8]
    else $error("second request lost after first was served");

  property p_hold_kept;
    @(posedge clk) disable iff (!resetn)
      irq.hold_set && !held_v_r |=> held_v_r && irq.svc_valid;
  endproperty
  a_hold_kept: assert property (p_hold_kept)  // see [RL7]
    else $error("request in entry window not held");
endmodule // shc_irq_store

// >>> design/shc_standby_ctrl.sv
// Standby mode register and halt sequencer, top of the block
`timescale 1ns/1ps
// Operation
// [RL1] Halt in stop mode drives the internal stop signal high.
// [RL2] With the stop pin drive keep bit set, the stop signal stays low.
// [RL3] Halt mode 00 is run, 01 stop, 10 idle, 11 is a don't care.
// [RL4] Clock output disable bits reset to 0, writes only set them.
// [RL5] Halt in stop mode drops the oscillator enable low.
// [RL6] One state lasts two oscillator periods.
// [RL7] NMI or external zero request in halt entry is held pending.
// [RL8] After entry a new interrupt releases halt; higher level served first.
module shc_standby_ctrl
  import shc_pkg::*;
(
  input  wire logic       clk,            // Oscillator clock, 25 MHz
  input  wire logic       resetn,         // Asynchronous reset, active low
  input  wire logic [7:0] addr,           // Register address
  input  wire logic [7:0] wdata,          // Register write data
  input  wire logic       wr,             // Write strobe
  input  wire logic       rd,             // Read strobe
  output logic      [7:0] rdata,          // Read data, cycle after rd
  input  wire logic       halt_exec,      // CPU executes halt, pulse
  input  wire logic       irq_req,        // Interrupt request, pulse
  input  wire logic [1:0] irq_src,        // Request source
  input  wire logic [2:0] irq_lvl,        // Request level
  input  wire logic       svc_ack,        // CPU takes offered request
  output logic            svc_valid,      // Request offered for service
  output logic      [1:0] svc_src,        // Source offered
  output logic            halted,         // CPU held in halt
  output logic            stop_sig,       // Internal stop, active high
  output logic            osc_en,         // Oscillator enable
  output logic            clk_out,        // Clock output level
  output logic            clk_out_oe,     // Clock output enable
  output logic            sysclk_out,     // System clock output level
  output logic            sysclk_out_oe,  // System clock output enable
  output logic            pseudo_sram_select, // Pseudo SRAM mode
  output logic            state_tick      // One pulse per state
);
  shc_irq_if irq ();

  logic       phase;
  logic       halt_mode_sel_hi_r, halt_mode_sel_hi_nxt;
  logic       halt_mode_sel_lo_r, halt_mode_sel_lo_nxt;
  logic       stop_pin_drive_keep_r, stop_pin_drive_keep_nxt;
  logic       clock_out_tristate_r, clock_out_tristate_nxt;
  logic       sys_clock_out_tristate_r, sys_clock_out_tristate_nxt;
  logic       pseudo_sram_select_r, pseudo_sram_select_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic [1:0] halt_mode;
  logic       reg_hit;
  shc_state_t st_r, st_nxt;
  logic [1:0] cnt_r, cnt_nxt;
  logic       stop_mode_r, stop_mode_nxt;
  logic       stop_sig_r, stop_sig_nxt;
  logic       osc_en_r, osc_en_nxt;
  logic       early_irq;

  shc_state_div u_div (
    .clk        (clk),
    .resetn     (resetn),
    .state_tick (state_tick),
    .phase      (phase)
  );

  shc_irq_store u_store (
    .clk    (clk),
    .resetn (resetn),
    .irq    (irq.store)
  );

  assign halt_mode = {halt_mode_sel_hi_r, halt_mode_sel_lo_r};
  assign reg_hit   = (addr == SHC_SMC_ADDR);

  // Register writes and read return
  always_comb
  begin
    halt_mode_sel_hi_nxt       = halt_mode_sel_hi_r;
    halt_mode_sel_lo_nxt       = halt_mode_sel_lo_r;
    stop_pin_drive_keep_nxt    = stop_pin_drive_keep_r;
    clock_out_tristate_nxt     = clock_out_tristate_r;
    sys_clock_out_tristate_nxt = sys_clock_out_tristate_r;
    pseudo_sram_select_nxt     = pseudo_sram_select_r;
    rdata_nxt                  = 8'h00;
    if (wr && reg_hit)
    begin
      halt_mode_sel_hi_nxt    = wdata[SHC_HALTM_HI_BIT];
      halt_mode_sel_lo_nxt    = wdata[SHC_HALTM_LO_BIT];
      stop_pin_drive_keep_nxt = wdata[SHC_KEEP_BIT];
      pseudo_sram_select_nxt  = wdata[SHC_PSRAM_BIT];
      // Writing 0 leaves the bit alone; only reset clears it
      clock_out_tristate_nxt  = clock_out_tristate_r
                                | wdata[SHC_CLKTRI_BIT];  // see [RL4]
      sys_clock_out_tristate_nxt = sys_clock_out_tristate_r
                                   | wdata[SHC_SCOUT_BIT];  // see [RL4]
    end
    // Pseudo SRAM bit is write-only and reads as 0
    if (rd && reg_hit)
    begin
      rdata_nxt[SHC_SCOUT_BIT]    = sys_clock_out_tristate_r;
      rdata_nxt[SHC_CLKTRI_BIT]   = clock_out_tristate_r;
      rdata_nxt[SHC_HALTM_HI_BIT] = halt_mode_sel_hi_r;
      rdata_nxt[SHC_HALTM_LO_BIT] = halt_mode_sel_lo_r;
      rdata_nxt[SHC_KEEP_BIT]     = stop_pin_drive_keep_r;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      halt_mode_sel_hi_r       <= SHC_SMC_RESET[SHC_HALTM_HI_BIT];
      halt_mode_sel_lo_r       <= SHC_SMC_RESET[SHC_HALTM_LO_BIT];
      stop_pin_drive_keep_r    <= SHC_SMC_RESET[SHC_KEEP_BIT];
      clock_out_tristate_r     <= SHC_SMC_RESET[SHC_CLKTRI_BIT];
      sys_clock_out_tristate_r <= SHC_SMC_RESET[SHC_SCOUT_BIT];
      pseudo_sram_select_r     <= SHC_SMC_RESET[SHC_PSRAM_BIT];
      rdata_r                  <= 8'h00;
    end
    else
    begin
      halt_mode_sel_hi_r       <= halt_mode_sel_hi_nxt;
      halt_mode_sel_lo_r       <= halt_mode_sel_lo_nxt;
      stop_pin_drive_keep_r    <= stop_pin_drive_keep_nxt;
      clock_out_tristate_r     <= clock_out_tristate_nxt;
      sys_clock_out_tristate_r <= sys_clock_out_tristate_nxt;
      pseudo_sram_select_r     <= pseudo_sram_select_nxt;
      rdata_r                  <= rdata_nxt;
    end
  end

  // Routing of requests: NMI and external zero in the entry window wait
  assign early_irq = irq_req && (st_r == SHC_ENTRY_S)
                     && (irq_src == SHC_SRC_NMI
                         || irq_src == SHC_SRC_EXT0);  // see [RL7]
  assign irq.hold_set = early_irq;
  assign irq.new_set  = irq_req && !early_irq;
  assign irq.req_src  = irq_src;
  assign irq.req_lvl  = shc_level(irq_src, irq_lvl);
  assign irq.svc_ack  = svc_ack;

  // Halt sequencer
  always_comb
  begin
    st_nxt        = st_r;
    cnt_nxt       = cnt_r;
    stop_mode_nxt = stop_mode_r;
    unique case (st_r)
      SHC_RUN_S:
        if (halt_exec)
        begin
          // Mode 11 is treated like run
          stop_mode_nxt = (halt_mode == SHC_MODE_STOP);  // see [RL3]
          cnt_nxt       = SHC_ENTRY_LAST;
          st_nxt        = shc_slow_entry(halt_mode) ? SHC_ENTRY_S
                                                    : SHC_HALT_S;
        end
      SHC_ENTRY_S:
      begin
        // Requests here do not release halt
        cnt_nxt = cnt_r - 2'h1;
        if (cnt_r == 2'h0)
          st_nxt = SHC_HALT_S;  // see [RL7]
      end
      SHC_HALT_S:
        if (irq_req)
        begin
          st_nxt        = SHC_RUN_S;  // see [RL8]
          stop_mode_nxt = 1'b0;
        end
    endcase
    stop_sig_nxt = (st_nxt != SHC_RUN_S) && stop_mode_nxt  // see [RL1]
                   && !stop_pin_drive_keep_nxt;  // see [RL2]
    osc_en_nxt   = !((st_nxt != SHC_RUN_S) && stop_mode_nxt);  // see [RL5]
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_r        <= SHC_RUN_S;
      cnt_r       <= 2'h0;
      stop_mode_r <= 1'b0;
      stop_sig_r  <= 1'b0;
      osc_en_r    <= 1'b1;
    end
    else
    begin
      st_r        <= st_nxt;
      cnt_r       <= cnt_nxt;
      stop_mode_r <= stop_mode_nxt;
      stop_sig_r  <= stop_sig_nxt;
      osc_en_r    <= osc_en_nxt;
    end
  end

  // Outputs
  assign rdata              = rdata_r;
  assign svc_valid          = irq.svc_valid;
  assign svc_src            = irq.svc_src;
  assign halted             = (st_r != SHC_RUN_S);
  assign stop_sig           = stop_sig_r;
  assign osc_en             = osc_en_r;
  assign clk_out            = phase;
  assign clk_out_oe         = !clock_out_tristate_r;  // see [RL4]
  assign sysclk_out         = phase;
  assign sysclk_out_oe      = !sys_clock_out_tristate_r;  // see [RL4]
  assign pseudo_sram_select = pseudo_sram_select_r;

  property p_stop_on_halt;
    @(posedge clk) disable iff (!resetn)
      (st_r == SHC_RUN_S) && halt_exec && (halt_mode == SHC_MODE_STOP)
        && !stop_pin_drive_keep_r && !wr
        |=> stop_sig ##1 stop_sig ##1 stop_sig;
  endproperty
  a_stop_on_halt: assert property (p_stop_on_halt)  // see [RL1]
    else $error("stop signal not raised on halt in stop mode");

  property p_keep_drive;
    @(posedge clk) disable iff (!resetn)
      stop_pin_drive_keep_r && $past(stop_pin_drive_keep_r) |-> !stop_sig;
  endproperty
  a_keep_drive: assert property (p_keep_drive)  // see [RL2]
    else $error("stop signal active with drive keep set");

  property p_idle_no_stop;
    @(posedge clk) disable iff (!resetn)
      (st_r == SHC_RUN_S) && halt_exec && (halt_mode != SHC_MODE_STOP)
        |=> !stop_sig && osc_en && halted;
  endproperty
  a_idle_no_stop: assert property (p_idle_no_stop)  // see [RL3]
    else $error("non-stop halt mode stopped the oscillator");

  property p_tristate_sticky;
    @(posedge clk) disable iff (!resetn)
      !clk_out_oe |=> !clk_out_oe ##1 !clk_out_oe;
  endproperty
  a_tristate_sticky: assert property (p_tristate_sticky)  // see [RL4]
    else $error("clock output re-enabled without reset");

  property p_osc_off;
    @(posedge clk) disable iff (!resetn)
      (st_r == SHC_RUN_S) && halt_exec && (halt_mode == SHC_MODE_STOP)
        |=> !osc_en throughout (st_r != SHC_RUN_S)[*3];
  endproperty
  a_osc_off: assert property (p_osc_off)  // see [RL5]
    else $error("oscillator enable stayed high in stop halt");

  property p_entry_len;
    @(posedge clk) disable iff (!resetn)
      (st_r == SHC_RUN_S) && halt_exec && shc_slow_entry(halt_mode)
        |=> (st_r == SHC_ENTRY_S)[*3] ##1 (st_r == SHC_HALT_S);
  endproperty
  a_entry_len: assert property (p_entry_len)  // see [RL7]
    else $error("halt entry window is not three clocks");

  property p_early_held;
    @(posedge clk) disable iff (!resetn)
      early_irq |=> halted && svc_valid;
  endproperty
  a_early_held: assert property (p_early_held)  // see [RL7]
    else $error("entry-window request released halt or was lost");

  property p_release;
    @(posedge clk) disable iff (!resetn)
      (st_r == SHC_HALT_S) && irq_req |=> !halted && osc_en && svc_valid;
  endproperty
  a_release: assert property (p_release)  // see [RL8]
    else $error("interrupt after entry did not release halt");

  property p_read_back;
    @(posedge clk) disable iff (!resetn)
      rd && reg_hit |=> rdata[SHC_CLKTRI_BIT] == clock_out_tristate_r
        && rdata[SHC_PSRAM_BIT] == 1'b0;
  endproperty
  a_read_back: assert property (p_read_back)  // see [RL4]
    else $error("register read data wrong");

  // Entry window never hands control back to the CPU
  property p_entry_holds;
    @(posedge clk) disable iff (!resetn)
      (st_r == SHC_ENTRY_S) |=> halted;
  endproperty
  a_entry_holds: assert property (p_entry_holds)  // see [RL7]
    else $error("halt released during the entry window");

  // A second halt while halted changes nothing
  property p_halt_ignored;
    @(posedge clk) disable iff (!resetn)
      (st_r != SHC_RUN_S) && halt_exec && !irq_req |=> halted;
  endproperty
  a_halt_ignored: assert property (p_halt_ignored)  // see [RL8]
    else $error("halt left without an interrupt");

  // Running CPU always has the oscillator live and stop low
  property p_run_osc_on;
    @(posedge clk) disable iff (!resetn)
      !halted |-> osc_en && !stop_sig;
  endproperty
  a_run_osc_on: assert property (p_run_osc_on)  // see [RL5]
    else $error("oscillator off or stop active while running");

  // Stop only appears inside a stop halt
  property p_stop_in_halt;
    @(posedge clk) disable iff (!resetn)
      stop_sig |-> halted && !osc_en;
  endproperty
  a_stop_in_halt: assert property (p_stop_in_halt)  // see [RL1]
    else $error("stop signal active outside a stop halt");
endmodule // shc_standby_ctrl

// >>> verif/tb.sv
// Self-checking testbench for the standby halt control block
`timescale 1ns/1ps
module tb
  import shc_pkg::*;
;
  logic        clk;
  logic        resetn;
  logic [7:0]  addr;
  logic [7:0]  wdata;
  logic        wr;
  logic        rd;
  logic [7:0]  rdata;
  logic        halt_exec;
  logic        irq_req;
  logic [1:0]  irq_src;
  logic [2:0]  irq_lvl;
  logic        svc_ack;
  logic        svc_valid;
  logic [1:0]  svc_src;
  logic        halted;
  logic        stop_sig;
  logic        osc_en;
  logic        clk_out;
  logic        clk_out_oe;
  logic        sysclk_out;
  logic        sysclk_out_oe;
  logic        pseudo_sram_select;
  logic        state_tick;
  int          errors;
  int          checks_done;
  logic [31:0] seed;
  logic [7:0]  mdl;
  logic        psram_m;
  logic        stp;
  logic [7:0]  ua;

  shc_standby_ctrl dut (
    .clk                (clk),
    .resetn             (resetn),
    .addr               (addr),
    .wdata              (wdata),
    .wr                 (wr),
    .rd                 (rd),
    .rdata              (rdata),
    .halt_exec          (halt_exec),
    .irq_req            (irq_req),
    .irq_src            (irq_src),
    .irq_lvl            (irq_lvl),
    .svc_ack            (svc_ack),
    .svc_valid          (svc_valid),
    .svc_src            (svc_src),
    .halted             (halted),
    .stop_sig           (stop_sig),
    .osc_en             (osc_en),
    .clk_out            (clk_out),
    .clk_out_oe         (clk_out_oe),
    .sysclk_out         (sysclk_out),
    .sysclk_out_oe      (sysclk_out_oe),
    .pseudo_sram_select (pseudo_sram_select),
    .state_tick         (state_tick)
  );

  // Oscillator clock, 40 ns period
  always #20 clk = ~clk;

  // Compare and count
  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Verdict and end of run
  task automatic conclude();
    if (errors == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Pseudo random source
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Register content after a write; tristate bits only set
  function automatic logic [7:0] reg_after(input logic [7:0] m,
                                           input logic [7:0] w);
    return {2'h0, m[5] | w[5], m[4] | w[4], w[3:2], 1'h0, w[0]};
  endfunction

  // Reset held for three clocks
  task automatic do_reset();
    resetn <= 1'b0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    mdl = SHC_SMC_RESET;
    psram_m = 1'b0;
  endtask

  // Register write cycle
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] w);
    @(posedge clk);
    addr  <= a;
    wdata <= w;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    if (a == SHC_SMC_ADDR)
    begin
      mdl = reg_after(mdl, w);
      psram_m = w[7];
    end
  endtask

  // Register read cycle, data in the following cycle
  task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk("rdata", exp, rdata);
  endtask

  // Pin enables follow the register
  task automatic chk_pins();
    chk("clk_out_oe", {7'h0, ~mdl[SHC_CLKTRI_BIT]},
        {7'h0, clk_out_oe});
    chk("sysclk_out_oe", {7'h0, ~mdl[SHC_SCOUT_BIT]},
        {7'h0, sysclk_out_oe});
    chk("pseudo_sram", {7'h0, psram_m}, {7'h0, pseudo_sram_select});
  endtask

  // Halt status outputs
  task automatic chk_halt(input logic h, input logic s, input logic o);
    chk("halted", {7'h0, h}, {7'h0, halted});
    chk("stop_sig", {7'h0, s}, {7'h0, stop_sig});
    chk("osc_en", {7'h0, o}, {7'h0, osc_en});
  endtask

  // Service offer outputs
  task automatic chk_svc(input logic v, input logic [1:0] s);
    chk("svc_valid", {7'h0, v}, {7'h0, svc_valid});
    if (v)
      chk("svc_src", {6'h0, s}, {6'h0, svc_src});
  endtask

  // One-cycle pulses
  task automatic halt_pulse();
    @(posedge clk);
    halt_exec <= 1'b1;
    @(posedge clk);
    halt_exec <= 1'b0;
    #1;
  endtask

  task automatic irq(input logic [1:0] s, input logic [2:0] l);
    @(posedge clk);
    irq_req <= 1'b1;
    irq_src <= s;
    irq_lvl <= l;
    @(posedge clk);
    irq_req <= 1'b0;
    #1;
  endtask

  task automatic ack();
    @(posedge clk);
    svc_ack <= 1'b1;
    @(posedge clk);
    svc_ack <= 1'b0;
    #1;
  endtask

  // State tick and clock output rate
  task automatic chk_tick();
    logic [7:0] n_tick;
    logic [7:0] n_pair;
    logic [7:0] n_tog;
    logic [7:0] n_stog;
    logic       p_tick;
    logic       p_clk;
    logic       p_sclk;
    n_tick = 8'h00;
    n_pair = 8'h00;
    n_tog  = 8'h00;
    n_stog = 8'h00;
    @(posedge clk);
    #1;
    p_tick = state_tick;
    p_clk  = clk_out;
    p_sclk = sysclk_out;
    repeat (8)
    begin
      @(posedge clk);
      #1;
      n_tick = n_tick + 8'(state_tick);
      n_pair = n_pair + 8'(state_tick & p_tick);
      n_tog  = n_tog + 8'(clk_out ^ p_clk);
      n_stog = n_stog + 8'(sysclk_out ^ p_sclk);
      p_tick = state_tick;
      p_clk  = clk_out;
      p_sclk = sysclk_out;
    end
    chk("tick count", 8'h04, n_tick);
    chk("tick pairs", 8'h00, n_pair);
    chk("clk_out toggles", 8'h08, n_tog);
    chk("sysclk_out toggles", 8'h08, n_stog);
  endtask

  // Request caught in entry, then a new one releases halt
  task automatic held_case(input logic [1:0] md, input logic [1:0] hs,
                           input logic [2:0] hl, input logic [1:0] ns,
                           input logic [2:0] nl, input logic [1:0] first,
                           input logic [1:0] second);
    reg_wr(SHC_SMC_ADDR, {4'h0, md, 2'h0});
    halt_pulse();
    irq(hs, hl);
    chk("halted in entry", 8'h01, {7'h0, halted});
    chk_svc(1'b1, hs);
    repeat (4) @(posedge clk);
    irq(ns, nl);
    chk("halted released", 8'h00, {7'h0, halted});
    chk_svc(1'b1, first);
    ack();
    chk_svc(1'b1, second);
    ack();
    chk_svc(1'b0, 2'h0);
  endtask

  // Watchdog
  initial
  begin
    #100000;
    errors++;
    conclude();
  end

  // Main sequence
  initial
  begin
    clk = 1'b0;
    resetn = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    halt_exec = 1'b0;
    irq_req = 1'b0;
    irq_src = 2'h0;
    irq_lvl = 3'h0;
    svc_ack = 1'b0;
    errors = 0;
    checks_done = 0;
    seed = 32'h4823;
    do_reset();
    #1;
    chk_halt(1'b0, 1'b0, 1'b1);
    chk_pins();
    reg_rd(SHC_SMC_ADDR, SHC_SMC_RESET);
    chk_tick();
    // Random writes, unmapped accesses and sticky tristate bits
    repeat (8)
    begin
      seed = lfsr(seed);
      ua = (seed[15:8] == SHC_SMC_ADDR) ? 8'h1f : seed[15:8];
      reg_wr(SHC_SMC_ADDR, seed[7:0]);
      reg_wr(ua, seed[23:16]);
      reg_rd(ua, 8'h00);
      reg_rd(SHC_SMC_ADDR, mdl);
      chk_pins();
    end
    reg_wr(SHC_SMC_ADDR, 8'hff);
    reg_wr(SHC_SMC_ADDR, 8'h00);
    reg_rd(SHC_SMC_ADDR, 8'h30);
    do_reset();
    #1;
    reg_rd(SHC_SMC_ADDR, SHC_SMC_RESET);
    chk_pins();
    // Every halt mode with and without drive keep
    for (int md = 0; md < 4; md++)
      for (int kp = 0; kp < 2; kp++)
      begin
        reg_wr(SHC_SMC_ADDR, {4'h0, 2'(md), 1'b0, 1'(kp)});
        halt_pulse();
        stp = (2'(md) == SHC_MODE_STOP) && (kp == 0);
        chk_halt(1'b1, stp,
                 ~(2'(md) == SHC_MODE_STOP));
        halt_pulse();
        repeat (3) @(posedge clk);
        irq(SHC_SRC_OTHER, 3'h1);
        chk_halt(1'b0, 1'b0, 1'b1);
        chk_svc(1'b1, SHC_SRC_OTHER);
        ack();
        chk_svc(1'b0, 2'h0);
      end
    held_case(SHC_MODE_STOP, SHC_SRC_NMI, 3'h0, SHC_SRC_EXT0, 3'h3,
              SHC_SRC_NMI, SHC_SRC_EXT0);
    held_case(SHC_MODE_IDLE, SHC_SRC_EXT0, 3'h2, SHC_SRC_OTHER, 3'h5,
              SHC_SRC_OTHER, SHC_SRC_EXT0);
    held_case(SHC_MODE_STOP, SHC_SRC_EXT0, 3'h4, SHC_SRC_OTHER, 3'h4,
              SHC_SRC_EXT0, SHC_SRC_OTHER);
    conclude();
  end
endmodule // tb
